// File: tsu_pkg.sv
// Purpose: constants, types and carriers of the task switch unit
// Assumes: APB register access, 32-bit data, 250 MHz clock
// Notes: task state segments kept in the 16-bit word layout
package tsu_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] TSU_CMD_OFF = 12'h000;
  localparam logic [11:0] TSU_STATUS_OFF = 12'h004;
  localparam logic [11:0] TSU_FLAGS_OFF = 12'h008;
  localparam logic [11:0] TSU_MSW_OFF = 12'h00c;
  localparam logic [11:0] TSU_TR_OFF = 12'h010;
  localparam logic [11:0] TSU_TRBASE_OFF = 12'h014;
  localparam logic [11:0] TSU_TRLIM_OFF = 12'h018;
  localparam logic [11:0] TSU_STACK_OFF = 12'h01c;
  localparam logic [6:0] TSU_DESC_PAGE = 7'h02;
  localparam logic [1:0] TSU_TSS_PAGE = 2'h1;

  // ==========================================================
  // field positions
  localparam int TSU_NT_BIT = 14;
  localparam int TSU_VM_BIT = 17;
  localparam int TSU_PE_BIT = 0;
  localparam int TSU_MP_BIT = 1;
  localparam int TSU_TS_BIT = 3;
  localparam int TSU_CMD_SLOT_LSB = 4;
  localparam int TSU_CMD_LVL_LSB = 8;
  localparam int TSU_DESC_TBIT = 4;
  localparam int TSU_DESC_GATE_LSB = 5;
  localparam int TSU_DESC_BASE_LSB = 8;
  localparam int TSU_DESC_LIM_LSB = 16;
  localparam int TSU_ST_BUSY_BIT = 0;
  localparam int TSU_ST_FAULT_BIT = 1;
  localparam int TSU_ST_VEC_LSB = 8;
  localparam int TSU_ST_FSM_LSB = 16;

  // ==========================================================
  // descriptor types, limits, vectors
  localparam logic [3:0] TSU_TYPE_AVL32 = 4'h9;
  localparam logic [3:0] TSU_TYPE_BSY32 = 4'hb;
  localparam logic [3:0] TSU_TYPE_AVL16 = 4'h1;
  localparam logic [3:0] TSU_TYPE_BSY16 = 4'h3;
  localparam logic [3:0] TSU_TYPE_GATE = 4'h5;
  localparam logic [15:0] TSU_MIN_LIM32 = 16'h0064;
  localparam logic [15:0] TSU_MIN_LIM16 = 16'h002b;
  localparam logic [7:0] TSU_VEC_DEBUG = 8'h01;
  localparam logic [7:0] TSU_VEC_NOCOP = 8'h07;
  localparam logic [7:0] TSU_VEC_BADTSS = 8'h0a;
  localparam logic [7:0] TSU_VEC_GP = 8'h0d;

  // ==========================================================
  // task state segment byte offsets
  localparam logic [5:0] TSU_TSS_BL = 6'h00;
  localparam logic [5:0] TSU_TSS_SP0 = 6'h02;
  localparam logic [5:0] TSU_TSS_FLAGS = 6'h10;
  localparam logic [5:0] TSU_TSS_LDT = 6'h2a;

  // ==========================================================
  // commands and reset values
  localparam logic [2:0] TSU_C_JMP = 3'h0;
  localparam logic [2:0] TSU_C_CALL = 3'h1;
  localparam logic [2:0] TSU_C_INT = 3'h2;
  localparam logic [2:0] TSU_C_INTERRUPT_RETURN = 3'h3;
  localparam logic [2:0] TSU_C_INTNT = 3'h4;
  localparam logic [2:0] TSU_C_STACK = 3'h5;
  localparam logic [2:0] TSU_C_ESC = 3'h6;
  localparam logic [2:0] TSU_C_WAIT = 3'h7;
  localparam logic [31:0] TSU_FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] TSU_MSW_RST = 32'h0000_0000;

  // ==========================================================
  // timing
  localparam int TSU_CLK_NS = 4;
  localparam int TSU_SWITCH_NS = 17000;
  localparam int TSU_SWITCH_CYC = TSU_SWITCH_NS / TSU_CLK_NS;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_SAVE = 5'h04,
    ST_LOAD = 5'h08,
    ST_WAIT = 5'h10
  } tsu_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tsu_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } tsu_apb_rsp_t;

endpackage : tsu_pkg

// File: tsu_task_switch_unit.sv
// Purpose: task switch unit with APB access to its state
// Assumes: one 250 MHz clock, async active-low reset
// Notes: descriptor slots and task segments are local memories
//
// Notes on behaviour
// - jump or call to a segment or task gate starts a switch.
// - interrupt through a task gate slot starts a switch.
// - switch checks, saves, loads, then resumes after about 17 us.
// - writing the task register reloads its hidden base and limit.
// - switching return saves current state, restores interrupted task.
// - nested flag bit 14 picks plain return or switch back.
// - call or interrupt switch marks busy, writes back link, sets flag.
// - non-switching interrupt clears nested flag, handler end restores it.
// - busy marking turns type 9H into BH, 1 into 3.
// - selecting a busy segment raises exception 13, no switch.
// - flag bit 17 marks legacy mode, changed only by switches.
// - no coprocessor save; every switch sets machine word bit 3.
// - first escape opcode after a switch raises exception 7.
// - escape or wait with both coprocessor flags set raises 7.
// - debug-trap bit in 32-bit segment raises exception 1 on entry.
// - after reset the unit runs in real mode.
// - writing protection-enable bit as one enters protected mode.
// - 16-bit layout: link 0, stacks 2 to C, local table 2A.
// - privilege change takes stack pair from current segment.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module tsu_task_switch_unit #(
  parameter int unsigned SWITCH_CYC = tsu_pkg::TSU_SWITCH_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tsu_pkg::tsu_apb_req_t apb_req,
  output tsu_pkg::tsu_apb_rsp_t apb_rsp,
  output logic exc_pulse,
  output logic [7:0] exc_vector,
  output logic pe_mode,
  output logic vm_mode
);
  import tsu_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    tsu_st_t st;
    logic [2:0] cause;
    logic [2:0] tgt;
    logic [2:0] old;
    logic gate_seen;
    logic [31:0] flags;
    logic [31:0] msw;
    logic [15:0] tr_sel;
    logic [7:0] tr_base;
    logic [15:0] tr_limit;
    logic fault;
    logic [7:0] vec;
    logic exc;
    logic [7:0] exc_vec;
    logic [12:0] cnt;
    logic dbg;
    logic nt_saved;
    logic [31:0] stack;
    logic [31:0] prdata;
    logic slverr;
  } tsu_regs_t;

  tsu_regs_t r_ff;
  tsu_regs_t nxt_r;
  logic [31:0] desc_mem [8];
  logic [31:0] tss_mem [256];

  // ==========================================================
  // helpers
  function automatic logic [7:0] tss_idx(logic [2:0] slot,
                                         logic [5:0] off);
    tss_idx = {slot, off[5:1]};
  endfunction : tss_idx

  function automatic logic is_avail(logic [3:0] t);
    is_avail = (t == TSU_TYPE_AVL32) || (t == TSU_TYPE_AVL16);
  endfunction : is_avail

  function automatic logic is_busy(logic [3:0] t);
    is_busy = (t == TSU_TYPE_BSY32) || (t == TSU_TYPE_BSY16);
  endfunction : is_busy

  function automatic logic [3:0] mk_busy(logic [3:0] t);
    mk_busy = (t == TSU_TYPE_AVL32) ? TSU_TYPE_BSY32 :
              (t == TSU_TYPE_AVL16) ? TSU_TYPE_BSY16 : t;
  endfunction : mk_busy

  function automatic logic [3:0] mk_avail(logic [3:0] t);
    mk_avail = (t == TSU_TYPE_BSY32) ? TSU_TYPE_AVL32 :
               (t == TSU_TYPE_BSY16) ? TSU_TYPE_AVL16 : t;
  endfunction : mk_avail

  function automatic tsu_regs_t raise(tsu_regs_t s, logic [7:0] v);
    raise = s;
    raise.exc = 1'b1;
    raise.exc_vec = v;
    raise.fault = 1'b1;
    raise.vec = v;
  endfunction : raise

  // ==========================================================
  // apb decode
  logic setup;
  logic wr_go;
  logic idle;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic is_desc;
  logic is_tss;
  logic addr_ok;
  logic [31:0] dt;
  logic [3:0] dtype;
  logic [31:0] ld_flags;
  logic [2:0] cur_slot;
  logic sw_call;
  logic [5:0] sp_off;

  assign addr = apb_req.paddr;
  assign wdata = apb_req.pwdata;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_go = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign idle = (r_ff.st == ST_IDLE);
  assign is_desc = (addr[11:5] == TSU_DESC_PAGE);
  assign is_tss = (addr[11:10] == TSU_TSS_PAGE);
  assign addr_ok = is_desc || is_tss || (addr <= TSU_STACK_OFF);
  assign dt = desc_mem[r_ff.tgt];
  assign dtype = dt[3:0];
  assign ld_flags = tss_mem[tss_idx(r_ff.tgt, TSU_TSS_FLAGS)];
  assign cur_slot = r_ff.tr_sel[5:3];
  assign sw_call = (r_ff.cause == TSU_C_CALL) || (r_ff.cause == TSU_C_INT);
  assign sp_off = TSU_TSS_SP0 + {wdata[TSU_CMD_LVL_LSB +: 2], 2'b00};

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = r_ff.prdata;
  assign apb_rsp.pslverr = r_ff.slverr;
  assign exc_pulse = r_ff.exc;
  assign exc_vector = r_ff.exc_vec;
  assign pe_mode = r_ff.msw[TSU_PE_BIT];
  assign vm_mode = r_ff.flags[TSU_VM_BIT];

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.exc = 1'b0;
    if (setup)
    begin
      nxt_r.slverr = !addr_ok;
      nxt_r.prdata = 32'h0;
      if (is_desc)
        nxt_r.prdata = desc_mem[addr[4:2]];
      else if (is_tss)
        nxt_r.prdata = tss_mem[addr[9:2]];
      else
      begin
        unique case (addr)
          TSU_STATUS_OFF:
          begin
            nxt_r.prdata[TSU_ST_BUSY_BIT] = !idle;
            nxt_r.prdata[TSU_ST_FAULT_BIT] = r_ff.fault;
            nxt_r.prdata[TSU_ST_VEC_LSB +: 8] = r_ff.vec;
            nxt_r.prdata[TSU_ST_FSM_LSB +: 5] = r_ff.st;
          end
          TSU_FLAGS_OFF: nxt_r.prdata = r_ff.flags;
          TSU_MSW_OFF: nxt_r.prdata = r_ff.msw;
          TSU_TR_OFF: nxt_r.prdata = {16'h0, r_ff.tr_sel};
          TSU_TRBASE_OFF: nxt_r.prdata = {24'h0, r_ff.tr_base};
          TSU_TRLIM_OFF: nxt_r.prdata = {16'h0, r_ff.tr_limit};
          TSU_STACK_OFF: nxt_r.prdata = r_ff.stack;
          default: nxt_r.prdata = 32'h0;
        endcase
      end
    end
    if (wr_go && addr == TSU_STATUS_OFF && wdata[TSU_ST_FAULT_BIT])
      nxt_r.fault = 1'b0;
    if (wr_go && idle)
    begin
      if (addr == TSU_FLAGS_OFF)
      begin
        nxt_r.flags = wdata;
        nxt_r.flags[TSU_VM_BIT] = r_ff.flags[TSU_VM_BIT];
      end
      if (addr == TSU_MSW_OFF)
        nxt_r.msw = wdata;
      if (addr == TSU_TR_OFF)
      begin
        nxt_r.tr_sel = wdata[15:0];
        nxt_r.tr_base = desc_mem[wdata[5:3]][TSU_DESC_BASE_LSB +: 8];
        nxt_r.tr_limit = desc_mem[wdata[5:3]][TSU_DESC_LIM_LSB +: 16];
      end
    end
    unique case (r_ff.st)
      ST_IDLE:
      begin
        if (wr_go && addr == TSU_CMD_OFF)
        begin
          nxt_r.cause = wdata[2:0];
          nxt_r.tgt = wdata[TSU_CMD_SLOT_LSB +: 3];
          nxt_r.old = cur_slot;
          nxt_r.gate_seen = 1'b0;
          unique case (wdata[2:0])
            TSU_C_JMP, TSU_C_CALL, TSU_C_INT:
              nxt_r.st = ST_CHECK;
            TSU_C_INTERRUPT_RETURN:
            begin
              if (r_ff.flags[TSU_NT_BIT])
              begin
                nxt_r.tgt = tss_mem[tss_idx(cur_slot, TSU_TSS_BL)][5:3];
                nxt_r.st = ST_CHECK;
              end
              else
                nxt_r.flags[TSU_NT_BIT] = r_ff.nt_saved;
            end
            TSU_C_INTNT:
            begin
              nxt_r.nt_saved = r_ff.flags[TSU_NT_BIT];
              nxt_r.flags[TSU_NT_BIT] = 1'b0;
            end
            TSU_C_STACK:
              nxt_r.stack = {tss_mem[tss_idx(cur_slot, sp_off + 6'h02)][15:0],
                             tss_mem[tss_idx(cur_slot, sp_off)][15:0]};
            TSU_C_ESC:
              if (r_ff.msw[TSU_TS_BIT])
                nxt_r = raise(nxt_r, TSU_VEC_NOCOP);
            TSU_C_WAIT:
              if (r_ff.msw[TSU_TS_BIT] && r_ff.msw[TSU_MP_BIT])
                nxt_r = raise(nxt_r, TSU_VEC_NOCOP);
          endcase
        end
      end
      ST_CHECK:
      begin
        if (dtype == TSU_TYPE_GATE)
        begin
          if (r_ff.gate_seen || r_ff.cause == TSU_C_INTERRUPT_RETURN)
          begin
            nxt_r = raise(nxt_r, TSU_VEC_GP);
            nxt_r.st = ST_IDLE;
          end
          else
          begin
            nxt_r.tgt = dt[TSU_DESC_GATE_LSB +: 3];
            nxt_r.gate_seen = 1'b1;
          end
        end
        else if ((r_ff.cause == TSU_C_INTERRUPT_RETURN) ? !is_busy(dtype) :
                 (!is_avail(dtype) ||
                  (r_ff.cause == TSU_C_INT && !r_ff.gate_seen)))
        begin
          nxt_r = raise(nxt_r, TSU_VEC_GP);
          nxt_r.st = ST_IDLE;
        end
        else if (dt[TSU_DESC_LIM_LSB +: 16] <=
                 ((dtype[3]) ? TSU_MIN_LIM32 : TSU_MIN_LIM16))
        begin
          nxt_r = raise(nxt_r, TSU_VEC_BADTSS);
          nxt_r.st = ST_IDLE;
        end
        else
          nxt_r.st = ST_SAVE;
      end
      ST_SAVE:
        nxt_r.st = ST_LOAD;
      ST_LOAD:
      begin
        nxt_r.flags = ld_flags;
        if (sw_call)
          nxt_r.flags[TSU_NT_BIT] = 1'b1;
        nxt_r.msw[TSU_TS_BIT] = 1'b1;
        nxt_r.tr_sel = {10'h0, r_ff.tgt, 3'h0};
        nxt_r.tr_base = dt[TSU_DESC_BASE_LSB +: 8];
        nxt_r.tr_limit = dt[TSU_DESC_LIM_LSB +: 16];
        nxt_r.dbg = dt[TSU_DESC_TBIT] && dtype[3];
        nxt_r.cnt = 13'h0;
        nxt_r.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (r_ff.cnt == 13'(SWITCH_CYC - 1))
        begin
          nxt_r.st = ST_IDLE;
          if (r_ff.dbg)
            nxt_r = raise(nxt_r, TSU_VEC_DEBUG);
        end
        else
          nxt_r.cnt = r_ff.cnt + 13'h1;
      end
      default:
        nxt_r.st = ST_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_ff <= '0;
      r_ff.st <= ST_IDLE;
      r_ff.flags <= TSU_FLAGS_RST;
      r_ff.msw <= TSU_MSW_RST;
    end
    else
      r_ff <= nxt_r;
  end

  // ==========================================================
  // descriptor and segment memories
  always_ff @(posedge clock)
  begin
    if (wr_go && idle && is_desc)
      desc_mem[addr[4:2]] <= wdata;
    if (wr_go && idle && is_tss)
      tss_mem[addr[9:2]] <= wdata;
    if (r_ff.st == ST_SAVE)
    begin
      tss_mem[tss_idx(r_ff.old, TSU_TSS_FLAGS)] <= r_ff.flags;
      if (r_ff.cause == TSU_C_JMP || r_ff.cause == TSU_C_INTERRUPT_RETURN)
        desc_mem[r_ff.old][3:0] <= mk_avail(desc_mem[r_ff.old][3:0]);
    end
    if (r_ff.st == ST_LOAD)
    begin
      if (sw_call)
        tss_mem[tss_idx(r_ff.tgt, TSU_TSS_BL)] <= {16'h0, r_ff.tr_sel};
      desc_mem[r_ff.tgt][3:0] <= mk_busy(dtype);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_switch_len: assert property (
    r_ff.st == ST_WAIT
      |-> (nxt_r.st == ST_IDLE) == (r_ff.cnt == 13'(SWITCH_CYC - 1)))
    else $error("switch length wrong");
  a_ts_on_switch: assert property (
    r_ff.st == ST_LOAD |=> r_ff.msw[TSU_TS_BIT] && r_ff.st == ST_WAIT)
    else $error("switched flag not set");
  a_busy_mark: assert property (
    r_ff.st == ST_LOAD |=> is_busy(desc_mem[$past(r_ff.tgt)][3:0]))
    else $error("incoming segment not busy");
  a_link_write: assert property (
    (r_ff.st == ST_LOAD && sw_call) |=>
      tss_mem[tss_idx($past(r_ff.tgt), TSU_TSS_BL)][15:0]
        == $past(r_ff.tr_sel) && r_ff.flags[TSU_NT_BIT])
    else $error("back link or nested flag wrong");
  a_jmp_no_nest: assert property (
    (r_ff.st == ST_LOAD && r_ff.cause == TSU_C_JMP) |=>
      r_ff.flags[TSU_NT_BIT] == $past(ld_flags[TSU_NT_BIT]))
    else $error("jump changed nested flag");
  a_fault_first: assert property (
    (r_ff.st == ST_CHECK && nxt_r.exc) |=> r_ff.st == ST_IDLE
      ##1 r_ff.st == ST_IDLE)
    else $error("fault after state change");
  a_busy_refuse: assert property (
    (r_ff.st == ST_CHECK && r_ff.cause == TSU_C_JMP && is_busy(dtype))
      |=> exc_pulse && exc_vector == TSU_VEC_GP)
    else $error("busy target not refused");
  a_cop_fault: assert property (
    (idle && wr_go && addr == TSU_CMD_OFF && wdata[2:0] == TSU_C_WAIT
      && r_ff.msw[TSU_TS_BIT] && r_ff.msw[TSU_MP_BIT])
      |=> exc_pulse && exc_vector == TSU_VEC_NOCOP ##1 !exc_pulse)
    else $error("wait did not fault");
  a_vm_hold: assert property (
    (idle && wr_go && addr == TSU_FLAGS_OFF)
      |=> $stable(r_ff.flags[TSU_VM_BIT]))
    else $error("legacy flag changed by write");
  a_tr_reload: assert property (
    (idle && wr_go && addr == TSU_TR_OFF) |=>
      r_ff.tr_limit == $past(desc_mem[wdata[5:3]][TSU_DESC_LIM_LSB +: 16]))
    else $error("hidden limit not reloaded");

  c_call_switch: cover property (
    r_ff.st == ST_LOAD && r_ff.cause == TSU_C_CALL);
  c_interrupt_return_switch: cover property (
    r_ff.st == ST_LOAD && r_ff.cause == TSU_C_INTERRUPT_RETURN);
  c_gp_fault: cover property (exc_pulse && exc_vector == TSU_VEC_GP);
  c_debug_entry: cover property (exc_pulse && exc_vector == TSU_VEC_DEBUG);

endmodule : tsu_task_switch_unit

// File: tsu_task_switch_unit_tb.sv
// Purpose: self-checking bench of the task switch unit
// Assumes: APB slave with pready high, switch wait shortened to 8 cycles
// Notes: exceptions are counted by a monitor on exc_pulse
`timescale 1ns/1ps
module tsu_task_switch_unit_tb;
  import tsu_pkg::*;

  // ==========================================================
  // signals
  localparam int unsigned SW_CYC = 8;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  tsu_apb_req_t apb_req = '0;
  tsu_apb_rsp_t apb_rsp;
  logic exc_pulse;
  logic [7:0] exc_vector;
  logic pe_mode;
  logic vm_mode;
  int fail_count = 0;
  int checks = 0;
  int exc_seen = 0;
  int exc_exp = 0;
  logic [31:0] rdat;
  logic err;

  tsu_task_switch_unit #(.SWITCH_CYC(SW_CYC)) dut (
    .clock(clock),
    .rst_n(rst_n),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .exc_pulse(exc_pulse),
    .exc_vector(exc_vector),
    .pe_mode(pe_mode),
    .vm_mode(vm_mode)
  );

  always #2 clock = ~clock;

  always @(posedge clock)
  begin
    if (exc_pulse === 1'b1)
      exc_seen <= exc_seen + 1;
  end

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic we, input logic [11:0] addr,
                     input logic [31:0] wdat, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clock);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= we;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wdat;
    @(posedge clock);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 100);
    if (n >= 100)
      chk("pready", {31'h0, apb_rsp.pready}, 32'h1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string what, input logic [11:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
  endtask : rd

  // issue a command, then poll until the unit is idle
  task automatic cmd(input logic [2:0] cause, input logic [2:0] slot,
                     input logic [1:0] lvl);
    logic [31:0] r;
    logic e;
    int n;
    wr(TSU_CMD_OFF, {22'h0, lvl, 1'b0, slot, 1'b0, cause});
    n = 0;
    do
    begin
      apb(1'b0, TSU_STATUS_OFF, 32'h0, r, e);
      n++;
    end
    while (r[TSU_ST_BUSY_BIT] !== 1'b0 && n < 40);
    if (n >= 40)
      chk("idle", {31'h0, r[TSU_ST_BUSY_BIT]}, 32'h0);
    repeat (2) @(posedge clock);
  endtask : cmd

  task automatic exc_chk(input string what, input int more,
                         input logic [7:0] vec);
    exc_exp += more;
    chk({what, " count"}, 32'(exc_seen), 32'(exc_exp));
    chk({what, " vector"}, {24'h0, exc_vector}, {24'h0, vec});
  endtask : exc_chk

  function automatic logic [11:0] seg(input int slot, input int off);
    return 12'(32'h400 + slot * 128 + off * 2);
  endfunction : seg

  function automatic logic [11:0] dsc(input int slot);
    return 12'(32'h40 + slot * 4);
  endfunction : dsc

  task automatic final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // ==========================================================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    final_report();
  end

  // ==========================================================
  // tests
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd("flags rst", TSU_FLAGS_OFF, TSU_FLAGS_RST);
    rd("msw rst", TSU_MSW_OFF, TSU_MSW_RST);
    chk("pe rst", {31'h0, pe_mode}, 32'h0);
    apb(1'b0, 12'h020, 32'h0, rdat, err);
    chk("unmapped data", rdat, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    // tables: slot1 running 32-bit, slot2 16-bit, slot3 gate, slot4 trap
    wr(dsc(1), 32'h0068_110b);
    wr(dsc(2), 32'h002c_2201);
    wr(dsc(3), 32'h0000_0045);
    wr(dsc(4), 32'h0070_4419);
    wr(seg(2, 16), 32'h0002_0002);
    wr(seg(4, 0), 32'h0000_1234);
    wr(seg(4, 16), 32'h0000_0002);
    wr(seg(4, 6), 32'h0000_5a5a);
    wr(seg(4, 8), 32'h0000_0033);
    wr(TSU_TR_OFF, 32'h0000_0008);
    rd("tr base", TSU_TRBASE_OFF, 32'h0000_0011);
    rd("tr limit", TSU_TRLIM_OFF, 32'h0000_0068);
    wr(TSU_MSW_OFF, 32'h0000_0001);
    // let the write settle before looking at the pin
    @(negedge clock);
    chk("pe on", {31'h0, pe_mode}, 32'h1);
    // interrupt through gate into the 16-bit task
    cmd(TSU_C_INT, 3'h3, 2'h0);
    rd("int tr", TSU_TR_OFF, 32'h0000_0010);
    rd("int base", TSU_TRBASE_OFF, 32'h0000_0022);
    rd("int busy", dsc(2), 32'h002c_2203);
    rd("int link", seg(2, 0), 32'h0000_0008);
    rd("int flags", TSU_FLAGS_OFF, 32'h0002_4002);
    chk("int vm", {31'h0, vm_mode}, 32'h1);
    rd("int msw", TSU_MSW_OFF, 32'h0000_0009);
    rd("int save", seg(1, 16), 32'h0000_0002);
    exc_chk("int", 0, 8'h00);
    // busy targets, direct and through the gate
    cmd(TSU_C_CALL, 3'h2, 2'h0);
    exc_chk("busy call", 1, TSU_VEC_GP);
    cmd(TSU_C_JMP, 3'h3, 2'h0);
    exc_chk("busy gate", 1, TSU_VEC_GP);
    rd("busy tr", TSU_TR_OFF, 32'h0000_0010);
    rd("busy out", dsc(1), 32'h0068_110b);
    rd("fault set", TSU_STATUS_OFF, 32'h0001_0d02);
    wr(TSU_STATUS_OFF, 32'h0000_0002);
    rd("fault clr", TSU_STATUS_OFF, 32'h0001_0d00);
    // coprocessor opcodes against switched and monitor flags
    cmd(TSU_C_ESC, 3'h0, 2'h0);
    exc_chk("esc ts", 1, TSU_VEC_NOCOP);
    cmd(TSU_C_WAIT, 3'h0, 2'h0);
    exc_chk("wait ts", 0, TSU_VEC_NOCOP);
    wr(TSU_MSW_OFF, 32'h0000_0001);
    cmd(TSU_C_ESC, 3'h0, 2'h0);
    exc_chk("esc clr", 0, TSU_VEC_NOCOP);
    wr(TSU_MSW_OFF, 32'h0000_000b);
    cmd(TSU_C_WAIT, 3'h0, 2'h0);
    exc_chk("wait mp", 1, TSU_VEC_NOCOP);
    // handler without switch, then plain return
    cmd(TSU_C_INTNT, 3'h0, 2'h0);
    rd("intnt flags", TSU_FLAGS_OFF, 32'h0002_0002);
    cmd(TSU_C_INTERRUPT_RETURN, 3'h0, 2'h0);
    rd("ret flags", TSU_FLAGS_OFF, 32'h0002_4002);
    rd("ret tr", TSU_TR_OFF, 32'h0000_0010);
    wr(TSU_FLAGS_OFF, 32'h0000_4002);
    rd("vm hold", TSU_FLAGS_OFF, 32'h0002_4002);
    chk("vm pin", {31'h0, vm_mode}, 32'h1);
    // return with nested flag set switches back
    wr(TSU_MSW_OFF, 32'h0000_0003);
    cmd(TSU_C_INTERRUPT_RETURN, 3'h0, 2'h0);
    rd("interrupt_return tr", TSU_TR_OFF, 32'h0000_0008);
    rd("interrupt_return free", dsc(2), 32'h002c_2201);
    rd("interrupt_return save", seg(2, 16), 32'h0002_4002);
    rd("interrupt_return flags", TSU_FLAGS_OFF, 32'h0000_0002);
    chk("interrupt_return vm", {31'h0, vm_mode}, 32'h0);
    rd("interrupt_return msw", TSU_MSW_OFF, 32'h0000_000b);
    exc_chk("interrupt_return", 0, TSU_VEC_NOCOP);
    // jump to the trapping 32-bit task
    cmd(TSU_C_JMP, 3'h4, 2'h0);
    exc_chk("jmp trap", 1, TSU_VEC_DEBUG);
    rd("jmp tr", TSU_TR_OFF, 32'h0000_0020);
    rd("jmp link", seg(4, 0), 32'h0000_1234);
    rd("jmp flags", TSU_FLAGS_OFF, 32'h0000_0002);
    rd("jmp busy", dsc(4), 32'h0070_441b);
    // stack pair for level 1 from the current segment
    cmd(TSU_C_STACK, 3'h0, 2'h1);
    rd("stack", TSU_STACK_OFF, 32'h0033_5a5a);
    // call straight to the free 16-bit segment
    cmd(TSU_C_CALL, 3'h2, 2'h0);
    rd("call tr", TSU_TR_OFF, 32'h0000_0010);
    rd("call link", seg(2, 0), 32'h0000_0020);
    rd("call flags", TSU_FLAGS_OFF, 32'h0002_4002);
    rd("call busy", dsc(2), 32'h002c_2203);
    rd("call save", seg(4, 16), 32'h0000_0002);
    exc_chk("call", 0, TSU_VEC_DEBUG);
    final_report();
  end

endmodule : tsu_task_switch_unit_tb
